/* File: rtl/bsq_boot_cmd.sv */
`timescale 1ns/1ps
`default_nettype none

module bsq_boot_cmd #(
   parameter logic [95:0] NAME_STR = 96'h5445_5354_4445_5630_3120_2020 // arbitrary
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // link setup
   input wire logic setup_done,
   // received bytes
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_fault,
   // bytes to send
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   // flash facts
   input wire logic [15:0] sum_value,
   input wire logic [31:0] soft_id,
   input wire logic rd_prot,
   input wire logic wr_prot,
   input wire logic sector_div,
   // erase engine
   output logic erase_start,
   input wire logic erase_done,
   input wire logic erase_ok,
   // commands served elsewhere
   output logic hand_valid,
   output logic [7:0] hand_cmd
);

   typedef enum logic [3:0] {
      ST_SETUP,
      ST_CMD,
      ST_SEND,
      ST_SUM_HI,
      ST_SUM_LO,
      ST_SUM_CK,
      ST_INFO,
      ST_INFO_CK,
      ST_ERA_KEY,
      ST_ERA_GO,
      ST_ERASE,
      ST_ERA_ACK
   } bsq_state_t;

   bsq_state_t st_ff;
   bsq_state_t ret_ff;
   logic tx_valid_ff;
   logic [7:0] tx_byte_ff;
   logic [7:0] csum_ff;
   logic [15:0] sum_hold_ff;
   logic [6:0] pos_ff;
   logic [3:0] prev_hi_ff;
   logic erase_start_ff;
   logic erase_ok_ff;
   logic hand_valid_ff;
   logic [7:0] hand_cmd_ff;

   logic cmd_take;
   logic cmd_known;
   logic key_take;

   bsq_info_if info ();

   bsq_info_rom #(
      .NAME_STR(NAME_STR)
   ) u_rom (
      .info(info.rom),
      .soft_id(soft_id),
      .rd_prot(rd_prot),
      .wr_prot(wr_prot),
      .sector_div(sector_div)
   );

   assign info.pos = pos_ff;

   // a byte is taken only while a command or the erase key is awaited
   assign cmd_take = (st_ff == ST_CMD) && rx_valid;
   assign key_take = (st_ff == ST_ERA_KEY) && rx_valid;

   always_comb begin
      unique case (rx_byte)
         bsq_pkg::CMD_RAM_XFER,
         bsq_pkg::CMD_SUM,
         bsq_pkg::CMD_INFO,
         bsq_pkg::CMD_ERASE,
         bsq_pkg::CMD_PROG: cmd_known = 1'b1;
         default: cmd_known = 1'b0;
      endcase
   end

   // upper nibble of the last cleanly taken defined command
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prev_hi_ff <= bsq_pkg::PREV_HI_RST;
      end else if (cmd_take && !rx_fault && cmd_known) begin
         prev_hi_ff <= rx_byte[7:4];
      end
   end

   // handoff of commands that other logic serves
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hand_valid_ff <= 1'b0;
         hand_cmd_ff <= 8'h00;
      end else begin
         hand_valid_ff <= cmd_take && !rx_fault &&
                          (rx_byte == bsq_pkg::CMD_RAM_XFER || rx_byte == bsq_pkg::CMD_PROG);
         if (cmd_take && !rx_fault) begin
            hand_cmd_ff <= rx_byte;
         end
      end
   end

   // erase request pulse and captured result
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         erase_start_ff <= 1'b0;
         erase_ok_ff <= 1'b0;
      end else begin
         erase_start_ff <= (st_ff == ST_ERA_GO);
         if (st_ff == ST_ERASE && erase_done) begin
            erase_ok_ff <= erase_ok;
         end
      end
   end

   // reply checksum: running sum over the data bytes of a reply
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         csum_ff <= 8'h00;
      end else begin
         unique case (st_ff)
            ST_SUM_HI: csum_ff <= sum_value[15:8];
            ST_SUM_LO: csum_ff <= bsq_pkg::cks_add(csum_ff, sum_hold_ff[7:0]);
            ST_INFO: csum_ff <= bsq_pkg::cks_add(csum_ff, info.data);
            ST_CMD: csum_ff <= 8'h00;
            default: csum_ff <= csum_ff;
         endcase
      end
   end

   // sum value is held so both halves come from one sample
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sum_hold_ff <= 16'h0000;
      end else if (st_ff == ST_SUM_HI) begin
         sum_hold_ff <= sum_value;
      end
   end

   // reply byte position
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pos_ff <= bsq_pkg::POS_SOFT_ID;
      end else if (st_ff == ST_CMD) begin
         pos_ff <= bsq_pkg::POS_SOFT_ID;
      end else if (st_ff == ST_INFO) begin
         pos_ff <= pos_ff + 7'h01;
      end
   end

   // sequencer and transmit holding register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= ST_SETUP;
         ret_ff <= ST_CMD;
         tx_valid_ff <= 1'b0;
         tx_byte_ff <= 8'h00;
      end else begin
         unique case (st_ff)
            ST_SETUP: begin
               if (setup_done) begin
                  st_ff <= ST_CMD;
               end
            end
            ST_CMD: begin
               if (rx_valid) begin
                  st_ff <= ST_SEND;
                  tx_valid_ff <= 1'b1;
                  ret_ff <= ST_CMD;
                  if (rx_fault) begin
                     tx_byte_ff <= {prev_hi_ff, bsq_pkg::ACK_COMM_ERR};
                  end else if (rx_byte == bsq_pkg::CMD_SUM) begin
                     tx_byte_ff <= rx_byte;
                     ret_ff <= ST_SUM_HI;
                  end else if (rx_byte == bsq_pkg::CMD_INFO) begin
                     tx_byte_ff <= rx_byte;
                     ret_ff <= ST_INFO;
                  end else if (rx_byte == bsq_pkg::CMD_ERASE) begin
                     tx_byte_ff <= rx_byte;
                     ret_ff <= ST_ERA_KEY;
                  end else if (cmd_known) begin
                     st_ff <= ST_CMD;
                     tx_valid_ff <= 1'b0;
                  end else begin
                     tx_byte_ff <= {prev_hi_ff, bsq_pkg::ACK_CMD_ERR};
                  end
               end
            end
            ST_SEND: begin
               if (tx_ready) begin
                  tx_valid_ff <= 1'b0;
                  st_ff <= ret_ff;
               end
            end
            ST_SUM_HI: begin
               tx_byte_ff <= sum_value[15:8];
               tx_valid_ff <= 1'b1;
               ret_ff <= ST_SUM_LO;
               st_ff <= ST_SEND;
            end
            ST_SUM_LO: begin
               tx_byte_ff <= sum_hold_ff[7:0];
               tx_valid_ff <= 1'b1;
               ret_ff <= ST_SUM_CK;
               st_ff <= ST_SEND;
            end
            ST_SUM_CK: begin
               tx_byte_ff <= bsq_pkg::cks_final(csum_ff);
               tx_valid_ff <= 1'b1;
               ret_ff <= ST_CMD;
               st_ff <= ST_SEND;
            end
            ST_INFO: begin
               tx_byte_ff <= info.data;
               tx_valid_ff <= 1'b1;
               ret_ff <= (pos_ff == bsq_pkg::POS_INFO_LAST) ? ST_INFO_CK : ST_INFO;
               st_ff <= ST_SEND;
            end
            ST_INFO_CK: begin
               tx_byte_ff <= bsq_pkg::cks_final(csum_ff);
               tx_valid_ff <= 1'b1;
               ret_ff <= ST_CMD;
               st_ff <= ST_SEND;
            end
            ST_ERA_KEY: begin
               if (key_take) begin
                  st_ff <= ST_SEND;
                  tx_valid_ff <= 1'b1;
                  ret_ff <= ST_CMD;
                  if (rx_fault) begin
                     tx_byte_ff <= {prev_hi_ff, bsq_pkg::ACK_COMM_ERR};
                  end else if (rx_byte == bsq_pkg::ERASE_KEY) begin
                     tx_byte_ff <= rx_byte;
                     ret_ff <= ST_ERA_GO;
                  end else begin
                     tx_byte_ff <= {prev_hi_ff, bsq_pkg::ACK_CMD_ERR};
                  end
               end
            end
            ST_ERA_GO: begin
               st_ff <= ST_ERASE;
            end
            ST_ERASE: begin
               if (erase_done) begin
                  tx_byte_ff <= erase_ok ? bsq_pkg::ERASE_END_OK : bsq_pkg::ERASE_END_BAD;
                  tx_valid_ff <= 1'b1;
                  ret_ff <= ST_ERA_ACK;
                  st_ff <= ST_SEND;
               end
            end
            ST_ERA_ACK: begin
               tx_byte_ff <= erase_ok_ff ? bsq_pkg::ERASE_ACK_OK : bsq_pkg::ERASE_ACK_BAD;
               tx_valid_ff <= 1'b1;
               ret_ff <= ST_CMD;
               st_ff <= ST_SEND;
            end
         endcase
      end
   end

   assign tx_valid = tx_valid_ff;
   assign tx_byte = tx_byte_ff;
   assign erase_start = erase_start_ff;
   assign hand_valid = hand_valid_ff;
   assign hand_cmd = hand_cmd_ff;

endmodule

`default_nettype wire

/* File: rtl/bsq_pkg.sv */
package bsq_pkg;

   // command codes seen as the third byte of an exchange, and the erase key that follows the erase command
   localparam logic [7:0] CMD_RAM_XFER = 8'h10;
   localparam logic [7:0] CMD_SUM = 8'h20;
   localparam logic [7:0] CMD_INFO = 8'h30;
   localparam logic [7:0] CMD_ERASE = 8'h40;
   localparam logic [7:0] CMD_PROG = 8'h50;
   localparam logic [7:0] ERASE_KEY = 8'h54;

   // low nibbles of the error acknowledges and the reset value of their upper nibble
   localparam logic [3:0] ACK_COMM_ERR = 4'h8;
   localparam logic [3:0] ACK_CMD_ERR = 4'h1;
   localparam logic [3:0] PREV_HI_RST = 4'h0;

   // erase result codes
   localparam logic [7:0] ERASE_END_OK = 8'h4f;
   localparam logic [7:0] ERASE_ACK_OK = 8'h5d;
   localparam logic [7:0] ERASE_END_BAD = 8'h4c;
   localparam logic [7:0] ERASE_ACK_BAD = 8'h60;

   // byte positions inside the product information reply
   localparam logic [6:0] POS_SOFT_ID = 7'h05;
   localparam logic [6:0] POS_NAME = 7'h09;
   localparam logic [6:0] POS_NAME_END = 7'h14;
   localparam logic [6:0] POS_PWD_ADDR = 7'h15;
   localparam logic [6:0] POS_RAM_START = 7'h19;
   localparam logic [6:0] POS_RAM_USR_END = 7'h1d;
   localparam logic [6:0] POS_RAM_END = 7'h21;
   localparam logic [6:0] POS_FILLER = 7'h25;
   localparam logic [6:0] POS_STATUS = 7'h2d;
   localparam logic [6:0] POS_FL_START = 7'h2f;
   localparam logic [6:0] POS_FL_END = 7'h33;
   localparam logic [6:0] POS_SECT_CNT = 7'h37;
   localparam logic [6:0] POS_SECT_ADDR = 7'h39;
   localparam logic [6:0] POS_SECT_SIZE = 7'h3d;
   localparam logic [6:0] POS_SECT_RUN = 7'h41;
   localparam logic [6:0] POS_INFO_LAST = 7'h41;

   // fixed values carried in the product information reply
   localparam logic [31:0] PWD_CMP_ADDR = 32'h0004fef4;
   localparam logic [31:0] RAM_START_ADDR = 32'h00001000;
   localparam logic [31:0] RAM_USR_END_ADDR = 32'h00004dff;
   localparam logic [31:0] RAM_END_ADDR = 32'h00004fff;
   localparam logic [31:0] FL_START_ADDR = 32'h00010000;
   localparam logic [31:0] FL_END_ADDR = 32'h0004ffff;
   localparam logic [15:0] SECT_COUNT = 16'h0040;
   localparam logic [31:0] SECT_WORDS = 32'h00000800;
   localparam logic [7:0] SECT_RUN = 8'h40;
   localparam logic [7:0] FILLER_BYTE = 8'h00;

   // status word bit positions
   localparam int ST_RD_BIT = 0;
   localparam int ST_WR_BIT = 1;
   localparam int ST_DIV_BIT = 2;

   // byte k of a word, least significant first
   function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] k);
      byte_of = w[{k, 3'b000} +: 8];
   endfunction

   function automatic logic [7:0] cks_add(input logic [7:0] acc, input logic [7:0] b);
      cks_add = acc + b;
   endfunction

   function automatic logic [7:0] cks_final(input logic [7:0] acc);
      cks_final = (~acc) + 8'h01;
   endfunction

endpackage

/* File: rtl/bsq_info_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface bsq_info_if;
   logic [6:0] pos;
   logic [7:0] data;

   modport fsm (output pos, input data);
   modport rom (input pos, output data);
endinterface

`default_nettype wire

/* File: rtl/bsq_info_rom.sv */
`timescale 1ns/1ps
`default_nettype none

// product information reply bytes, addressed by byte number
module bsq_info_rom #(
   parameter logic [95:0] NAME_STR = 96'h5445_5354_4445_5630_3120_2020
) (
   bsq_info_if.rom info,
   // flash contents and state
   input wire logic [31:0] soft_id,
   input wire logic rd_prot,
   input wire logic wr_prot,
   input wire logic sector_div
);

   logic [6:0] rel;
   logic [15:0] status;

   always_comb begin
      status = 16'h0000;
      status[bsq_pkg::ST_RD_BIT] = ~rd_prot;
      status[bsq_pkg::ST_WR_BIT] = ~wr_prot;
      status[bsq_pkg::ST_DIV_BIT] = ~sector_div;
   end

   always_comb begin
      rel = 7'h00;
      info.data = bsq_pkg::FILLER_BYTE;
      if (info.pos < bsq_pkg::POS_NAME) begin
         rel = info.pos - bsq_pkg::POS_SOFT_ID;
         info.data = bsq_pkg::byte_of(soft_id, rel[1:0]);
      end else if (info.pos <= bsq_pkg::POS_NAME_END) begin
         rel = bsq_pkg::POS_NAME_END - info.pos;
         info.data = NAME_STR[{rel[3:0], 3'b000} +: 8];
      end else if (info.pos < bsq_pkg::POS_RAM_START) begin
         rel = info.pos - bsq_pkg::POS_PWD_ADDR;
         info.data = bsq_pkg::byte_of(bsq_pkg::PWD_CMP_ADDR, rel[1:0]);
      end else if (info.pos < bsq_pkg::POS_RAM_USR_END) begin
         rel = info.pos - bsq_pkg::POS_RAM_START;
         info.data = bsq_pkg::byte_of(bsq_pkg::RAM_START_ADDR, rel[1:0]);
      end else if (info.pos < bsq_pkg::POS_RAM_END) begin
         rel = info.pos - bsq_pkg::POS_RAM_USR_END;
         info.data = bsq_pkg::byte_of(bsq_pkg::RAM_USR_END_ADDR, rel[1:0]);
      end else if (info.pos < bsq_pkg::POS_FILLER) begin
         rel = info.pos - bsq_pkg::POS_RAM_END;
         info.data = bsq_pkg::byte_of(bsq_pkg::RAM_END_ADDR, rel[1:0]);
      end else if (info.pos < bsq_pkg::POS_STATUS) begin
         info.data = bsq_pkg::FILLER_BYTE;
      end else if (info.pos < bsq_pkg::POS_FL_START) begin
         rel = info.pos - bsq_pkg::POS_STATUS;
         info.data = rel[0] ? status[15:8] : status[7:0];
      end else if (info.pos < bsq_pkg::POS_FL_END) begin
         rel = info.pos - bsq_pkg::POS_FL_START;
         info.data = bsq_pkg::byte_of(bsq_pkg::FL_START_ADDR, rel[1:0]);
      end else if (info.pos < bsq_pkg::POS_SECT_CNT) begin
         rel = info.pos - bsq_pkg::POS_FL_END;
         info.data = bsq_pkg::byte_of(bsq_pkg::FL_END_ADDR, rel[1:0]);
      end else if (info.pos < bsq_pkg::POS_SECT_ADDR) begin
         rel = info.pos - bsq_pkg::POS_SECT_CNT;
         info.data = rel[0] ? bsq_pkg::SECT_COUNT[15:8] : bsq_pkg::SECT_COUNT[7:0];
      end else if (info.pos < bsq_pkg::POS_SECT_SIZE) begin
         rel = info.pos - bsq_pkg::POS_SECT_ADDR;
         info.data = bsq_pkg::byte_of(bsq_pkg::FL_START_ADDR, rel[1:0]);
      end else if (info.pos < bsq_pkg::POS_SECT_RUN) begin
         rel = info.pos - bsq_pkg::POS_SECT_SIZE;
         info.data = bsq_pkg::byte_of(bsq_pkg::SECT_WORDS, rel[1:0]);
      end else if (info.pos == bsq_pkg::POS_SECT_RUN) begin
         info.data = bsq_pkg::SECT_RUN;
      end
   end

endmodule

`default_nettype wire

/* File: verif/bsq_boot_cmd_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module bsq_boot_cmd_assertions (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // receive and transmit
   input wire logic setup_done,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_fault,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_ready,
   // erase and hand-off
   input wire logic erase_start,
   input wire logic erase_done,
   input wire logic erase_ok,
   input wire logic hand_valid,
   input wire logic [7:0] hand_cmd
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // a byte arriving after setup while nothing is being sent is taken
   wire logic take = setup_done && rx_valid && !tx_valid;
   logic key_ff;

   // marks that the pending reply is the erase key echo
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         key_ff <= 1'b0;
      else if (take)
         key_ff <= !rx_fault && rx_byte == 8'h54;
      else if (tx_valid && tx_ready)
         key_ff <= 1'b0;
   end

   tx_hold_a:
      assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
         else $error("reply byte changed before acceptance");
   tx_gap_a:
      assert property (tx_valid && tx_ready |=> !tx_valid)
         else $error("no idle cycle after accepted byte");
   fault_ack_a:
      assert property (take && rx_fault |=> tx_valid && tx_byte[3:0] == 4'h8)
         else $error("receive fault not answered with x8");
   bad_cmd_a:
      assert property (take && !rx_fault && !(rx_byte inside {8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h54})
         |=> tx_valid && tx_byte[3:0] == 4'h1) else $error("unknown command not answered with x1");
   cmd_echo_a:
      assert property (take && !rx_fault && rx_byte inside {8'h20, 8'h30, 8'h40}
         |=> tx_valid && tx_byte == $past(rx_byte)) else $error("command not echoed");
   hand_off_a:
      assert property (take && !rx_fault && rx_byte inside {8'h10, 8'h50}
         |=> hand_valid && hand_cmd == $past(rx_byte) && !tx_valid) else $error("hand-off missing");
   erase_go_a:
      assert property (key_ff && tx_valid && tx_ready && tx_byte == 8'h54 |-> ##2 erase_start)
         else $error("erase not started after key echo");
   erase_end_a:
      assert property (erase_done |=> tx_valid && tx_byte == ($past(erase_ok) ? 8'h4f : 8'h4c))
         else $error("wrong erase end code");

   cover property (take && !rx_fault && rx_byte == 8'h20);
   cover property (take && !rx_fault && rx_byte == 8'h30);
   cover property (erase_done && erase_ok);
   cover property (erase_done && !erase_ok);
endmodule

bind bsq_boot_cmd bsq_boot_cmd_assertions bsq_boot_cmd_assertions_inst (
   .core_clk(core_clk), .rstn(rstn), .setup_done(setup_done), .rx_valid(rx_valid),
   .rx_byte(rx_byte), .rx_fault(rx_fault), .tx_valid(tx_valid), .tx_byte(tx_byte),
   .tx_ready(tx_ready), .erase_start(erase_start), .erase_done(erase_done),
   .erase_ok(erase_ok), .hand_valid(hand_valid), .hand_cmd(hand_cmd));

`default_nettype wire

/* File: verif/bsq_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none

module bsq_ctrl_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // device reply side
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic tx_ready,
   // stall control and collected bytes
   input wire logic slow,
   output logic got,
   output logic [7:0] got_byte
);
   // a slow controller accepts on random cycles only
   always @(negedge core_clk) begin
      tx_ready <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         got <= 1'b0;
         got_byte <= 8'h00;
      end else begin
         got <= tx_valid && tx_ready;
         got_byte <= tx_byte;
      end
   end
endmodule

`default_nettype wire

/* File: verif/boot_serial_query_erase_cmds_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module boot_serial_query_erase_cmds_tb;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic setup_done = 1'b0;
   logic rx_valid = 1'b0;
   logic rx_fault = 1'b0;
   logic [7:0] rx_byte = 8'h00;
   logic [15:0] sum_value = 16'h0000;
   logic [31:0] soft_id = 32'h00000000;
   logic rd_prot = 1'b0;
   logic wr_prot = 1'b0;
   logic sector_div = 1'b0;
   logic erase_done = 1'b0;
   logic erase_ok = 1'b0;
   logic slow = 1'b0;
   logic tx_valid, tx_ready, erase_start, hand_valid, got;
   logic [7:0] tx_byte, hand_cmd, got_byte;
   logic [8:0] exp_q[$];
   int error_cnt = 0;
   int comparisons = 0;
   localparam logic [95:0] NAME = "TESTDEV01   ";
   localparam logic [191:0] FIX_A = 192'hf4fe0400_00100000_ff4d0000_ff4f0000_00000000_00000000;
   localparam logic [151:0] FIX_B = 152'h00000100_ffff0400_4000_00000100_00080000_40;

   always #25 core_clk = ~core_clk;

   bsq_boot_cmd #(.NAME_STR(NAME)) bsq_boot_cmd_inst (.core_clk(core_clk), .rstn(rstn), .setup_done(setup_done),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_fault(rx_fault), .tx_valid(tx_valid),
      .tx_byte(tx_byte), .tx_ready(tx_ready), .sum_value(sum_value), .soft_id(soft_id),
      .rd_prot(rd_prot), .wr_prot(wr_prot), .sector_div(sector_div), .erase_start(erase_start),
      .erase_done(erase_done), .erase_ok(erase_ok), .hand_valid(hand_valid), .hand_cmd(hand_cmd));

   bsq_ctrl_model bsq_ctrl_model_inst (.core_clk(core_clk), .rstn(rstn), .tx_valid(tx_valid),
      .tx_byte(tx_byte), .tx_ready(tx_ready), .slow(slow), .got(got), .got_byte(got_byte));

   task automatic summarize();
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [8:0] e, input logic [8:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   task automatic hang(input string what);
      error_cnt++;
      $display("wrong value at %0t: %s", $time, what);
      summarize();
   endtask

   // every reply byte or hand-off is matched against the oldest note
   always @(posedge core_clk) begin
      if (got || hand_valid)
         chk(exp_q.size() ? exp_q.pop_front() : 9'h1ff, {hand_valid, got ? got_byte : hand_cmd});
   end

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic send(input logic [7:0] b, input logic f);
      @(negedge core_clk);
      rx_valid = 1'b1;
      rx_byte = b;
      rx_fault = f;
      @(negedge core_clk);
      rx_valid = 1'b0;
      rx_byte = ~b;
      rx_fault = ~f;
   endtask

   task automatic put(input logic [7:0] b);
      exp_q.push_back({1'b0, b});
   endtask

   task automatic frame(input logic [7:0] fr[$]);
      logic [7:0] s;
      s = 8'h00;
      foreach (fr[i]) begin
         put(fr[i]);
         s = s + fr[i];
      end
      put(~s + 8'h01);
   endtask

   task automatic drain();
      int n;
      n = 0;
      while (exp_q.size() != 0) begin
         if (n == 3000)
            hang("reply missing");
         @(negedge core_clk);
         n++;
      end
      tick(4);
   endtask

   task automatic run_sum();
      logic [7:0] fr[$];
      sum_value = 16'($urandom);
      send(8'h20, 1'b0);
      put(8'h20);
      fr.push_back(sum_value[15:8]);
      fr.push_back(sum_value[7:0]);
      frame(fr);
      drain();
   endtask

   task automatic run_info();
      logic [7:0] fr[$];
      soft_id = $urandom;
      {rd_prot, wr_prot, sector_div} = 3'($urandom);
      send(8'h30, 1'b0);
      put(8'h30);
      for (int i = 0; i < 4; i++) fr.push_back(soft_id[8*i +: 8]);
      for (int i = 0; i < 12; i++) fr.push_back(NAME[95-8*i -: 8]);
      for (int i = 0; i < 24; i++) fr.push_back(FIX_A[191-8*i -: 8]);
      fr.push_back({5'h00, ~sector_div, ~wr_prot, ~rd_prot});
      fr.push_back(8'h00);
      for (int i = 0; i < 19; i++) fr.push_back(FIX_B[151-8*i -: 8]);
      frame(fr);
      drain();
   endtask

   task automatic run_erase(input logic [7:0] key, input logic f, input logic ok);
      int n;
      send(8'h40, 1'b0);
      put(8'h40);
      drain();
      send(key, f);
      if (f)
         put(8'h48);
      else if (key != 8'h54)
         put(8'h41);
      else begin
         put(8'h54);
         n = 0;
         while (!erase_start) begin
            if (n == 300)
               hang("erase never started");
            @(negedge core_clk);
            n++;
         end
         erase_ok = ok;
         tick(3);
         erase_done = 1'b1;
         @(negedge core_clk);
         erase_done = 1'b0;
         erase_ok = !ok;
         put(ok ? 8'h4f : 8'h4c);
         put(ok ? 8'h5d : 8'h60);
      end
      drain();
   endtask

   initial begin
      void'($urandom(32'h3ded));
      tick(5);
      rstn = 1'b1;
      send(8'h20, 1'b0);
      tick(4);
      setup_done = 1'b1;
      tick(2);
      send(8'h77, 1'b0);
      put(8'h01);
      drain();
      for (int i = 0; i < 3; i++) begin
         slow = 1'($urandom);
         run_sum();
      end
      for (int i = 0; i < 2; i++) begin
         slow = 1'($urandom);
         run_info();
      end
      // a stalling controller from here on, so held reply bytes are exercised
      slow = 1'b1;
      send(8'($urandom), 1'b1);
      put(8'h38);
      drain();
      send(8'h10, 1'b0);
      exp_q.push_back({1'b1, 8'h10});
      drain();
      send(8'h5a, 1'b0);
      put(8'h11);
      drain();
      run_erase(8'h55, 1'b0, 1'b0);
      run_erase(8'h54, 1'b1, 1'b0);
      run_erase(8'h54, 1'b0, 1'b1);
      run_erase(8'h54, 1'b0, 1'b0);
      send(8'h50, 1'b0);
      exp_q.push_back({1'b1, 8'h50});
      drain();
      // reset between exchanges clears the remembered upper nibble
      rstn = 1'b0;
      tick(2);
      rstn = 1'b1;
      tick(2);
      send(8'h6b, 1'b0);
      put(8'h01);
      drain();
      summarize();
   end
endmodule

`default_nettype wire
